//--- hw/ddr_port_pkg.sv
// Shared constants and types for the registered command port.
// Assumes a single 20 MHz clock domain and an active-low asynchronous reset.
package ddr_port_pkg;

  localparam int ADDR_W     = 13;
  localparam int DATA_W     = 72;
  localparam int MASK_W     = 9;
  localparam int BANKS      = 4;
  localparam int WORD_W     = DATA_W + MASK_W;
  localparam int SYNC_N     = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int BURST_WORDS = 4;

  localparam int AUTO_PRE_BIT = 10;

  localparam logic [1:0] MODE_SEL_BASE = 2'h0;
  localparam logic [1:0] MODE_SEL_EXT  = 2'h1;

  localparam logic [ADDR_W-1:0] MODE_RST  = 13'h0000;
  localparam logic [BANKS-1:0]  OPEN_RST  = 4'h0;
  localparam logic [3:0]        LEFT_RST  = 4'h0;
  localparam logic [DATA_W-1:0] DOUT_RST  = 72'h0;

  localparam real CLK_PERIOD_NS = 50.0;

  // Command code is the row, column and write strobes in that order.
  typedef enum logic [2:0] {
    CMD_LOAD_MODE  = 3'h0,
    CMD_REFRESH    = 3'h1,
    CMD_PRECHARGE  = 3'h2,
    CMD_ACTIVATE   = 3'h3,
    CMD_WRITE      = 3'h4,
    CMD_READ       = 3'h5,
    CMD_BURST_STOP = 3'h6,
    CMD_NOP        = 3'h7
  } cmd_type;

  typedef enum logic [1:0] {
    PWR_ACTIVE         = 2'h0,
    PWR_PRECHARGE_DOWN = 2'h1,
    PWR_ACTIVE_DOWN    = 2'h2,
    PWR_SELF_REFRESH   = 2'h3
  } pwr_type;

endpackage

//--- hw/ddr_command_port.sv
// Registered command port of a double-data-rate module with its write FIFO.
// Assumes the host drives command pins on i_ref_clk and never lets it stop.

module data_fifo #(
  parameter int WIDTH = 81,
  parameter int DEPTH = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 count;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } fifo_type;

  fifo_type st_r;
  fifo_type st_nxt;
  logic     do_push;
  logic     do_pop;

  // The output stage is a register so the drain side sees no mux path.
  always_comb begin
    st_nxt     = st_r;
    // The output register holds a word too, so it counts toward the depth.
    o_in_ready = ((st_r.count + (PW+1)'(st_r.out_valid))
                  != (PW+1)'(DEPTH));
    do_push    = i_in_valid && o_in_ready;
    do_pop     = (st_r.count != '0) && (!st_r.out_valid || i_out_ready);
    if (i_out_ready && st_r.out_valid) begin
      st_nxt.out_valid = 1'b0;
    end
    if (do_pop) begin
      st_nxt.out_valid = 1'b1;
      st_nxt.out_data  = st_r.mem[st_r.rd_ptr];
      st_nxt.rd_ptr    = st_r.rd_ptr + 1'b1;
    end
    if (do_push) begin
      st_nxt.mem[st_r.wr_ptr] = i_in_data;
      st_nxt.wr_ptr           = st_r.wr_ptr + 1'b1;
    end
    st_nxt.count = st_r.count + (PW+1)'(do_push) - (PW+1)'(do_pop);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_out_valid = st_r.out_valid;
  assign o_out_data  = st_r.out_data;
endmodule

module ddr_command_port
  import ddr_port_pkg::*;
#(
  parameter int BURST = BURST_WORDS
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_chip_select_n,
  input  wire logic              i_row_strobe_n,
  input  wire logic              i_col_strobe_n,
  input  wire logic              i_write_enable_n,
  input  wire logic              i_bank_select_lo,
  input  wire logic              i_bank_select_hi,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_clock_gate_in,
  input  wire logic [MASK_W-1:0] i_write_mask,
  input  wire logic [63:0]       i_data_lines,
  input  wire logic [7:0]        i_check_bits,
  input  wire logic              i_data_strobe,
  input  wire logic              i_rd_valid,
  input  wire logic [DATA_W-1:0] i_rd_data,
  input  wire logic              i_mem_wr_ready,
  output logic                   o_cmd_chip_select_n,
  output logic                   o_cmd_row_strobe_n,
  output logic                   o_cmd_col_strobe_n,
  output logic                   o_cmd_write_enable_n,
  output logic      [1:0]        o_cmd_bank,
  output logic      [ADDR_W-1:0] o_cmd_addr,
  output logic                   o_clock_gate_out,
  output logic                   o_cmd_valid,
  output logic      [2:0]        o_cmd_code,
  output logic                   o_auto_precharge,
  output logic      [BANKS-1:0]  o_bank_open,
  output logic      [ADDR_W-1:0] o_mode_reg,
  output logic      [ADDR_W-1:0] o_ext_mode_reg,
  output logic      [1:0]        o_power_state,
  output logic                   o_internal_clk_en,
  output logic                   o_inbuf_en,
  output logic                   o_clk_inbuf_en,
  output logic                   o_out_drive_en,
  output logic      [63:0]       o_data_lines,
  output logic      [7:0]        o_check_bits,
  output logic                   o_data_oe_n,
  output logic                   o_data_strobe,
  output logic                   o_strobe_oe_n,
  output logic                   o_mem_wr_valid,
  output logic      [DATA_W-1:0] o_mem_wr_data,
  output logic      [MASK_W-1:0] o_mem_wr_mask,
  output logic                   o_write_ready
);
  typedef struct packed {
    logic                           cs_n;
    logic                           ras_n;
    logic                           cas_n;
    logic                           we_n;
    logic [1:0]                     bank;
    logic [ADDR_W-1:0]              addr;
    logic                           cke;
    logic                           cmd_valid;
    cmd_type                        cmd;
    logic                           auto_pre;
    logic [BANKS-1:0]               open;
    logic [ADDR_W-1:0]              mode;
    logic [ADDR_W-1:0]              ext_mode;
    pwr_type                        pwr;
    logic                           clk_en;
    logic                           inbuf_en;
    logic                           clk_inbuf_en;
    logic                           drive_en;
    logic [SYNC_N-1:0]              cke_sync;
    logic                           cke_stable;
    logic [SYNC_N-1:0]              stb_sync;
    logic                           stb_stable;
    logic [SYNC_N-1:0][WORD_W-1:0]  wr_pipe;
    logic [3:0]                     wr_left;
    logic [DATA_W-1:0]              dout;
    logic                           dout_oe_n;
    logic                           stb;
    logic                           stb_oe_n;
    logic                           push;
    logic [WORD_W-1:0]              push_word;
    logic                           wr_ready;
    logic                           seen;
  } state_type;

  state_type             st_r;
  state_type             st_nxt;
  logic                  fifo_in_ready;
  logic [WORD_W-1:0]     fifo_out;
  logic                  bank_used;
  logic                  stb_edge;

  function automatic logic [BANKS-1:0] bank_bit(input logic [1:0] b);
    bank_bit = BANKS'(1) << b;
  endfunction

  always_comb begin
    st_nxt = st_r;
    // One register stage between the pins and the memory devices.
    st_nxt.cs_n  = i_chip_select_n;
    st_nxt.ras_n = i_row_strobe_n;
    st_nxt.cas_n = i_col_strobe_n;
    st_nxt.we_n  = i_write_enable_n;
    st_nxt.bank  = {i_bank_select_hi, i_bank_select_lo};
    st_nxt.addr  = i_addr;
    st_nxt.cke   = i_clock_gate_in;
    // Masked by chip select and by disabled input buffers.
    st_nxt.cmd_valid = !i_chip_select_n && st_r.inbuf_en;
    st_nxt.cmd = cmd_type'({i_row_strobe_n, i_col_strobe_n,
                            i_write_enable_n});
    st_nxt.auto_pre = i_addr[AUTO_PRE_BIT];

    // The raw gate takes the refresh exit path, so it is resynchronised.
    st_nxt.cke_sync = {st_r.cke_sync[SYNC_N-2:0], i_clock_gate_in};
    if (st_r.cke_sync[2] == st_r.cke_sync[1]) begin
      st_nxt.cke_stable = st_r.cke_sync[2];
    end
    st_nxt.stb_sync = {st_r.stb_sync[SYNC_N-2:0], i_data_strobe};
    if (st_r.stb_sync[2] == st_r.stb_sync[1]) begin
      st_nxt.stb_stable = st_r.stb_sync[2];
    end
    stb_edge = (st_nxt.stb_stable != st_r.stb_stable);
    st_nxt.wr_pipe = {st_r.wr_pipe[SYNC_N-2:0],
                      {i_check_bits, i_data_lines, i_write_mask}};

    // Each settled strobe transition while wr_left is nonzero captures the delayed word.
    // A write command in the same cycle reloads the count below and wins.
    st_nxt.push = 1'b0;
    if (stb_edge && st_r.wr_left != LEFT_RST) begin
      st_nxt.push      = 1'b1;
      st_nxt.push_word = st_r.wr_pipe[SYNC_N-1];
      st_nxt.wr_left   = st_r.wr_left - 4'h1;
    end

    if (st_r.cmd_valid) begin
      unique case (st_r.cmd)
        CMD_ACTIVATE: begin
          st_nxt.open = st_r.open | bank_bit(st_r.bank);
        end
        CMD_PRECHARGE: begin
          if (st_r.addr[AUTO_PRE_BIT]) begin
            st_nxt.open = OPEN_RST;
          end else begin
            st_nxt.open = st_r.open & ~bank_bit(st_r.bank);
          end
        end
        CMD_READ, CMD_WRITE: begin
          if (st_r.auto_pre) begin
            st_nxt.open = st_r.open & ~bank_bit(st_r.bank);
          end
          if (st_r.cmd == CMD_WRITE) begin
            st_nxt.wr_left = 4'(BURST);
          end
        end
        CMD_LOAD_MODE: begin
          if (st_r.bank == MODE_SEL_BASE) begin
            st_nxt.mode = st_r.addr;
          end else if (st_r.bank == MODE_SEL_EXT) begin
            st_nxt.ext_mode = st_r.addr;
          end
        end
        CMD_REFRESH, CMD_BURST_STOP, CMD_NOP: begin
        end
      endcase
    end

    st_nxt.wr_ready = fifo_in_ready;

    bank_used = (st_r.open != OPEN_RST);
    unique case (st_r.pwr)
      PWR_ACTIVE: begin
        if (!st_r.cke) begin
          if (st_r.cmd_valid && st_r.cmd == CMD_REFRESH) begin
            st_nxt.pwr = PWR_SELF_REFRESH;
          end else if (bank_used) begin
            st_nxt.pwr = PWR_ACTIVE_DOWN;
          end else begin
            st_nxt.pwr = PWR_PRECHARGE_DOWN;
          end
        end
      end
      PWR_PRECHARGE_DOWN, PWR_ACTIVE_DOWN: begin
        if (st_r.cke) begin
          st_nxt.pwr = PWR_ACTIVE;
        end
      end
      PWR_SELF_REFRESH: begin
        // The settled copy lags the pin, so the registered gate must agree.
        if (st_r.cke_stable && st_r.cke) begin
          st_nxt.pwr = PWR_ACTIVE;
        end
      end
    endcase
    st_nxt.clk_en       = (st_nxt.pwr == PWR_ACTIVE);
    st_nxt.inbuf_en     = (st_nxt.pwr == PWR_ACTIVE);
    st_nxt.clk_inbuf_en = (st_nxt.pwr != PWR_SELF_REFRESH);
    st_nxt.drive_en = (st_nxt.pwr == PWR_ACTIVE) && st_nxt.cke_stable;

    // Strobe toggles with each read word taken while drive_en is set, so it is edge aligned.
    st_nxt.dout_oe_n = 1'b1;
    st_nxt.stb_oe_n  = 1'b1;
    if (i_rd_valid && st_r.drive_en) begin
      st_nxt.dout      = i_rd_data;
      st_nxt.dout_oe_n = 1'b0;
      st_nxt.stb_oe_n  = 1'b0;
      st_nxt.stb       = !st_r.stb;
    end
    st_nxt.seen = 1'b1;
  end

  // Every register resets low except the two enables, which keep pins off.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r           <= '0;
      st_r.dout_oe_n <= 1'b1;
      st_r.stb_oe_n  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // A full FIFO drops a strobed word; o_write_ready warns the host first.
  data_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (st_r.push),
    .i_in_data   (st_r.push_word),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_mem_wr_valid),
    .o_out_data  (fifo_out),
    .i_out_ready (i_mem_wr_ready)
  );

  assign o_mem_wr_data        = fifo_out[WORD_W-1:MASK_W];
  assign o_mem_wr_mask        = fifo_out[MASK_W-1:0];
  assign o_cmd_chip_select_n  = st_r.cs_n;
  assign o_cmd_row_strobe_n   = st_r.ras_n;
  assign o_cmd_col_strobe_n   = st_r.cas_n;
  assign o_cmd_write_enable_n = st_r.we_n;
  assign o_cmd_bank           = st_r.bank;
  assign o_cmd_addr           = st_r.addr;
  assign o_clock_gate_out     = st_r.cke;
  assign o_cmd_valid          = st_r.cmd_valid;
  assign o_cmd_code           = st_r.cmd;
  assign o_auto_precharge     = st_r.auto_pre;
  assign o_bank_open          = st_r.open;
  assign o_mode_reg           = st_r.mode;
  assign o_ext_mode_reg       = st_r.ext_mode;
  assign o_power_state        = st_r.pwr;
  assign o_internal_clk_en    = st_r.clk_en;
  assign o_inbuf_en           = st_r.inbuf_en;
  assign o_clk_inbuf_en       = st_r.clk_inbuf_en;
  assign o_out_drive_en       = st_r.drive_en;
  assign o_data_lines         = st_r.dout[63:0];
  assign o_check_bits         = st_r.dout[DATA_W-1:64];
  assign o_data_oe_n          = st_r.dout_oe_n;
  assign o_data_strobe        = st_r.stb;
  assign o_strobe_oe_n        = st_r.stb_oe_n;
  assign o_write_ready        = st_r.wr_ready;

  property p_reset_low;
    @(posedge i_ref_clk) disable iff (1'b0)
      !i_rst_n |-> (o_cmd_addr == '0) && !o_clock_gate_out
      && (o_power_state == PWR_ACTIVE);
  endproperty
  a_reset_low: assert property (p_reset_low)
    else $error("input register not low in reset");

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_one_clock;
    st_r.seen |-> (o_cmd_addr == $past(i_addr))
      && (o_clock_gate_out == $past(i_clock_gate_in));
  endproperty
  a_one_clock: assert property (p_one_clock)
    else $error("command path is not one clock late");

  property p_select_mask;
    o_cmd_valid |-> !o_cmd_chip_select_n && (o_cmd_code == $past(
      {i_row_strobe_n, i_col_strobe_n, i_write_enable_n}));
  endproperty
  a_select_mask: assert property (p_select_mask)
    else $error("command accepted with chip select high");

  property p_activate;
    o_cmd_valid && o_cmd_code == CMD_ACTIVATE |=> o_bank_open[$past(o_cmd_bank)];
  endproperty
  a_activate: assert property (p_activate)
    else $error("activate did not open its bank");

  property p_precharge;
    o_cmd_valid && o_cmd_code == CMD_PRECHARGE && o_cmd_addr[AUTO_PRE_BIT]
      |=> o_bank_open == '0;
  endproperty
  a_precharge: assert property (p_precharge)
    else $error("precharge all left a bank open");

  property p_mode_load;
    o_cmd_valid && o_cmd_code == CMD_LOAD_MODE && o_cmd_bank == MODE_SEL_EXT
      |=> (o_ext_mode_reg == $past(o_cmd_addr)) && $stable(o_mode_reg);
  endproperty
  a_mode_load: assert property (p_mode_load)
    else $error("extended mode register not loaded");

  property p_active_down;
    o_power_state == PWR_ACTIVE && !o_clock_gate_out && o_bank_open != '0
      && !(o_cmd_valid && o_cmd_code == CMD_REFRESH)
      |=> (o_power_state == PWR_ACTIVE_DOWN) && !o_inbuf_en;
  endproperty
  a_active_down: assert property (p_active_down)
    else $error("active power-down not entered");

  property p_refresh_hold;
    o_power_state == PWR_SELF_REFRESH && !st_r.cke_stable
      |=> o_power_state == PWR_SELF_REFRESH;
  endproperty
  a_refresh_hold: assert property (p_refresh_hold)
    else $error("self refresh left without a settled gate");

  property p_refresh_bufs;
    o_power_state == PWR_SELF_REFRESH |-> !o_clk_inbuf_en && !o_inbuf_en
      && !o_internal_clk_en;
  endproperty
  a_refresh_bufs: assert property (p_refresh_bufs)
    else $error("buffers active in self refresh");

  property p_read_strobe;
    !o_data_oe_n |-> !o_strobe_oe_n && (o_data_strobe != $past(o_data_strobe));
  endproperty
  a_read_strobe: assert property (p_read_strobe)
    else $error("read strobe not aligned to data");

  c_self_refresh: cover property (o_power_state == PWR_SELF_REFRESH);
  c_active_down: cover property (o_power_state == PWR_ACTIVE_DOWN);
  c_write_word: cover property (o_mem_wr_valid && i_mem_wr_ready);
  c_read_word: cover property (!o_data_oe_n ##1 !o_data_oe_n);
endmodule

//--- verification/host_ctrl_model.sv
// Host controller model driving the command, clock gate and write data pins.
// Assumes the bench calls its tasks; every pin changes on a falling edge.
module host_ctrl_model
  import ddr_port_pkg::*;
(
  input  wire logic              i_ref_clk,
  output logic                   o_chip_select_n,
  output logic                   o_row_strobe_n,
  output logic                   o_col_strobe_n,
  output logic                   o_write_enable_n,
  output logic      [1:0]        o_bank,
  output logic      [ADDR_W-1:0] o_addr,
  output logic                   o_clock_gate,
  output logic      [MASK_W-1:0] o_write_mask,
  output logic      [DATA_W-1:0] o_data,
  output logic                   o_data_strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_chip_select_n = 1'b1;
    {o_row_strobe_n, o_col_strobe_n, o_write_enable_n} = CMD_NOP;
    o_bank = 2'h0;
    o_addr = 13'h0000;
    o_clock_gate = 1'b1;
    o_write_mask = 9'h000;
    o_data = 72'h0;
    o_data_strobe = 1'b0;
  end

  // Falling-edge changes keep every pin still across the rising crossing.
  task automatic cmd(input logic cs_n, input cmd_type code,
                     input logic [1:0] bank, input logic [ADDR_W-1:0] addr,
                     input logic gate);
    @(negedge i_ref_clk);
    o_chip_select_n = cs_n;
    {o_row_strobe_n, o_col_strobe_n, o_write_enable_n} = code;
    o_bank = bank;
    o_addr = addr;
    o_clock_gate = gate;
  endtask

  // A deselected address keeps moving so a stale value is never trusted.
  task automatic idle();
    @(negedge i_ref_clk);
    o_chip_select_n = 1'b1;
    {o_row_strobe_n, o_col_strobe_n, o_write_enable_n} = CMD_NOP;
    o_addr = ~o_addr;
  endtask

  // The strobe flips with each new word, which is then held five cycles, so it lands inside the data eye.
  task automatic wr_word(input logic [DATA_W-1:0] d,
                         input logic [MASK_W-1:0] m);
    @(negedge i_ref_clk);
    o_data = d;
    o_write_mask = m;
    o_data_strobe = ~o_data_strobe;
    repeat (5) @(negedge i_ref_clk);
    o_data = ~d;
    o_write_mask = ~m;
  endtask
endmodule

//--- verification/ddr_command_port_tb.sv
// Self-checking bench for the registered command port and its write FIFO.
// Assumes the host model drives the pins and a 20 MHz clock with async reset.
module ddr_command_port_tb
  import ddr_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BURST_N = 4;
  typedef struct packed {
    logic [2:0]        code;
    logic [1:0]        bank;
    logic [ADDR_W-1:0] addr;
    int                due;
  } cmd_note_type;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    int                due;
  } rd_note_type;

  logic              i_ref_clk, i_rst_n, cs_n, ras_n, cas_n, we_n, gate;
  logic              wstrobe, rd_valid, wr_ready, drain, rd_strb;
  logic [1:0]        bank, o_cmd_bank, o_power_state;
  logic [ADDR_W-1:0] addr, o_cmd_addr, o_mode_reg, o_ext_mode_reg;
  logic [MASK_W-1:0] wmask, o_mem_wr_mask;
  logic [DATA_W-1:0] wdata, rd_data, o_mem_wr_data;
  logic              o_cmd_chip_select_n, o_clock_gate_out, o_cmd_valid;
  logic              o_auto_precharge, o_internal_clk_en, o_inbuf_en;
  logic              o_clk_inbuf_en, o_out_drive_en, o_data_oe_n;
  logic              o_data_strobe, o_strobe_oe_n, o_mem_wr_valid;
  logic              o_write_ready, o_cmd_row_strobe_n, o_cmd_col_strobe_n;
  logic              o_cmd_write_enable_n;
  logic [2:0]        o_cmd_code;
  logic [BANKS-1:0]  o_bank_open;
  logic [63:0]       o_data_lines;
  logic [7:0]        o_check_bits;
  logic [95:0]       r, dv;
  int                n_errors, checked, cyc, seed;
  cmd_note_type      cmd_q[$];
  rd_note_type       rd_q[$];
  logic [WORD_W-1:0] wr_q[$];

  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  host_ctrl_model host (.i_ref_clk(i_ref_clk), .o_chip_select_n(cs_n),
    .o_row_strobe_n(ras_n), .o_col_strobe_n(cas_n), .o_write_enable_n(we_n),
    .o_bank(bank), .o_addr(addr), .o_clock_gate(gate),
    .o_write_mask(wmask), .o_data(wdata), .o_data_strobe(wstrobe));

  ddr_command_port #(.BURST(BURST_N)) uut (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_chip_select_n(cs_n), .i_row_strobe_n(ras_n),
    .i_col_strobe_n(cas_n), .i_write_enable_n(we_n),
    .i_bank_select_lo(bank[0]), .i_bank_select_hi(bank[1]), .i_addr(addr),
    .i_clock_gate_in(gate), .i_write_mask(wmask),
    .i_data_lines(wdata[63:0]), .i_check_bits(wdata[71:64]),
    .i_data_strobe(wstrobe), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .i_mem_wr_ready(wr_ready), .o_cmd_chip_select_n(o_cmd_chip_select_n),
    .o_cmd_row_strobe_n(o_cmd_row_strobe_n),
    .o_cmd_col_strobe_n(o_cmd_col_strobe_n),
    .o_cmd_write_enable_n(o_cmd_write_enable_n),
    .o_cmd_bank(o_cmd_bank), .o_cmd_addr(o_cmd_addr),
    .o_clock_gate_out(o_clock_gate_out), .o_cmd_valid(o_cmd_valid),
    .o_cmd_code(o_cmd_code), .o_auto_precharge(o_auto_precharge),
    .o_bank_open(o_bank_open), .o_mode_reg(o_mode_reg),
    .o_ext_mode_reg(o_ext_mode_reg), .o_power_state(o_power_state),
    .o_internal_clk_en(o_internal_clk_en), .o_inbuf_en(o_inbuf_en),
    .o_clk_inbuf_en(o_clk_inbuf_en), .o_out_drive_en(o_out_drive_en),
    .o_data_lines(o_data_lines), .o_check_bits(o_check_bits),
    .o_data_oe_n(o_data_oe_n), .o_data_strobe(o_data_strobe),
    .o_strobe_oe_n(o_strobe_oe_n), .o_mem_wr_valid(o_mem_wr_valid),
    .o_mem_wr_data(o_mem_wr_data), .o_mem_wr_mask(o_mem_wr_mask),
    .o_write_ready(o_write_ready));

  function automatic logic [95:0] rnd();
    rnd = {$random(seed), $random(seed), $random(seed)};
  endfunction

  task automatic cmp(input string nm, input logic [127:0] e,
                     input logic [127:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_cmd();
    cmd_note_type n;
    if (cmd_q.size() == 0) cmp("cmd_extra", 128'h0, 128'h1);
    else begin
      n = cmd_q.pop_front();
      cmp("cmd", {n.code, n.code, 1'b0, n.bank, n.addr, n.addr[AUTO_PRE_BIT],
          n.due}, {o_cmd_code, o_cmd_row_strobe_n, o_cmd_col_strobe_n,
          o_cmd_write_enable_n, o_cmd_chip_select_n, o_cmd_bank, o_cmd_addr,
          o_auto_precharge, cyc});
    end
  endtask

  task automatic chk_rd();
    rd_note_type n;
    if (rd_q.size() == 0) cmp("rd_extra", 128'h0, 128'h1);
    else begin
      n = rd_q.pop_front();
      cmp("rd", {n.data, ~rd_strb, 1'b0, n.due},
          {o_check_bits, o_data_lines, o_data_strobe, o_strobe_oe_n, cyc});
    end
    rd_strb = o_data_strobe;
  endtask

  task automatic chk_wr();
    if (wr_q.size() == 0) cmp("wr_extra", 128'h0, 128'h1);
    else cmp("wr", wr_q.pop_front(), {o_mem_wr_mask, o_mem_wr_data});
  endtask

  task automatic chk_pwr(input pwr_type s);
    cmp("pwr", {s, s == PWR_ACTIVE, s == PWR_ACTIVE,
        s != PWR_SELF_REFRESH, 1'b0}, {o_power_state, o_internal_clk_en,
        o_inbuf_en, o_clk_inbuf_en, (s != PWR_ACTIVE) && o_out_drive_en});
  endtask

  task automatic send(input logic cs, input cmd_type c, input logic [1:0] b,
                      input logic [ADDR_W-1:0] a, input logic g,
                      input logic ok);
    host.cmd(cs, c, b, a, g);
    if (ok) cmd_q.push_back('{c, b, a, cyc + 2});
  endtask

  task automatic rd(input logic ok);
    @(negedge i_ref_clk);
    r = rnd();
    rd_valid = 1'b1;
    rd_data = r[71:0];
    if (ok) rd_q.push_back('{r[71:0], cyc + 2});
  endtask

  task automatic rd_stop();
    @(negedge i_ref_clk);
    rd_valid = 1'b0;
    rd_data = ~rd_data;
  endtask

  task automatic wait_n(input int k);
    repeat (k) @(negedge i_ref_clk);
  endtask

  task automatic wait_drive();
    for (int i = 0; i < 20 && o_out_drive_en !== 1'b1; i++) wait_n(1);
    cmp("drive_en", 128'h1, o_out_drive_en);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  always @(posedge i_ref_clk) begin
    cyc++;
    if (i_rst_n === 1'b1) begin
      if (o_cmd_valid !== 1'b0) chk_cmd();
      if (o_data_oe_n !== 1'b1) chk_rd();
      if (o_mem_wr_valid !== 1'b0 && wr_ready === 1'b1) chk_wr();
    end
  end

  always @(negedge i_ref_clk) begin
    if (drain) begin
      dv = rnd();
      wr_ready <= dv[0];
    end
  end

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    cmp("timeout", 128'h0, 128'h1);
    report_and_stop();
  end

  initial begin
    seed = 11965;
    {n_errors, checked, cyc} = '0;
    {rd_strb, drain, rd_valid, wr_ready, i_rst_n} = 5'h00;
    rd_data = 72'h0;
    wait_n(2);
    cmp("reset", 128'h30, {o_cmd_chip_select_n, o_clock_gate_out, o_cmd_valid,
        o_bank_open, o_data_oe_n, o_strobe_oe_n, o_power_state,
        o_mem_wr_valid, o_write_ready});
    wait_n(18);
    i_rst_n = 1'b1;
    wait_drive();
    for (int c = 0; c < 8; c++) begin
      r = rnd();
      send(1'b0, cmd_type'(c), r[14:13], r[12:0], 1'b1, 1'b1);
    end
    r = rnd();
    send(1'b0, CMD_LOAD_MODE, 2'h0, r[12:0], 1'b1, 1'b1);
    send(1'b0, CMD_LOAD_MODE, 2'h1, r[25:13], 1'b1, 1'b1);
    send(1'b0, CMD_LOAD_MODE, 2'h2, r[38:26], 1'b1, 1'b1);
    host.idle();
    wait_n(2);
    cmp("mode", {r[12:0], r[25:13]}, {o_mode_reg, o_ext_mode_reg});
    done("mode");
    send(1'b0, CMD_PRECHARGE, 2'h0, 13'h0400, 1'b1, 1'b1);
    for (int b = 0; b < 4; b++)
      send(1'b0, CMD_ACTIVATE, b[1:0], r[51:39], 1'b1, 1'b1);
    send(1'b0, CMD_PRECHARGE, 2'h2, r[64:52] & 13'h1BFF, 1'b1, 1'b1);
    send(1'b0, CMD_READ, 2'h1, r[77:65] | 13'h0400, 1'b1, 1'b1);
    send(1'b1, CMD_PRECHARGE, 2'h0, 13'h0400, 1'b1, 1'b0);
    host.idle();
    wait_n(2);
    cmp("open", 128'h9, o_bank_open);
    send(1'b0, CMD_PRECHARGE, 2'h3, 13'h0400, 1'b1, 1'b1);
    send(1'b1, CMD_ACTIVATE, 2'h1, 13'h0000, 1'b1, 1'b0);
    host.idle();
    wait_n(2);
    cmp("open", 128'h0, o_bank_open);
    done("bank");
    repeat (3) rd(1'b1);
    rd_stop();
    wait_n(3);
    done("read");
    send(1'b1, CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b0);
    wait_n(2);
    chk_pwr(PWR_PRECHARGE_DOWN);
    send(1'b0, CMD_ACTIVATE, 2'h0, 13'h0000, 1'b0, 1'b0);
    rd(1'b0);
    rd_stop();
    send(1'b1, CMD_NOP, 2'h0, 13'h0000, 1'b1, 1'b0);
    wait_n(2);
    chk_pwr(PWR_ACTIVE);
    cmp("open", 128'h0, o_bank_open);
    wait_drive();
    send(1'b0, CMD_ACTIVATE, 2'h3, 13'h0000, 1'b1, 1'b1);
    host.idle();
    send(1'b1, CMD_NOP, 2'h0, 13'h0000, 1'b0, 1'b0);
    wait_n(2);
    chk_pwr(PWR_ACTIVE_DOWN);
    send(1'b1, CMD_NOP, 2'h0, 13'h0000, 1'b1, 1'b0);
    wait_n(2);
    chk_pwr(PWR_ACTIVE);
    wait_drive();
    send(1'b0, CMD_PRECHARGE, 2'h0, 13'h0400, 1'b1, 1'b1);
    host.idle();
    send(1'b0, CMD_REFRESH, 2'h0, 13'h0000, 1'b0, 1'b1);
    host.idle();
    wait_n(1);
    chk_pwr(PWR_SELF_REFRESH);
    wait_n(4);
    chk_pwr(PWR_SELF_REFRESH);
    send(1'b1, CMD_NOP, 2'h0, 13'h0000, 1'b1, 1'b0);
    for (int i = 0; i < 12 && o_power_state !== PWR_ACTIVE; i++) wait_n(1);
    chk_pwr(PWR_ACTIVE);
    wait_drive();
    done("power");
    for (int k = 0; k < 20; k++) begin
      if (k % BURST_N == 0) begin
        send(1'b0, CMD_WRITE, 2'h0, 13'h0000, 1'b1, 1'b1);
        host.idle();
      end
      r = rnd();
      cmp("wr_ready", 128'(k < FIFO_DEPTH), o_write_ready);
      if (k < FIFO_DEPTH) wr_q.push_back({r[80:72], r[71:0]});
      host.wr_word(r[71:0], r[80:72]);
    end
    drain = 1'b1;
    for (int i = 0; i < 600 && wr_q.size() > 0; i++) wait_n(1);
    cmp("drained", 128'h0, wr_q.size());
    host.wr_word(r[71:0], 9'h000);
    wait_n(10);
    done("write");
    report_and_stop();
  end
endmodule
